// ---- fp_exception_detect.sv ----
// Top: floating-point exception detection, control register and trap report
//
// What this block does
// - Bad-operand trap always on, result unpredictable
// - Legacy reserved or dirty-zero operand flags bad
// - IEEE NaN, infinity, denormal operand flags bad
// - IEEE zero over zero is bad, not divide
// - Legacy valid over zero flags divide by zero
// - IEEE divide by zero needs nonzero valid numerator
// - Overflow always on, floating destinations only
// - Underflow forces all-zero 64-bit destination
// - Underflow always recorded, trapped only if enabled
// - Inexact always recorded, trapped only if enabled
// - Enabled inexact accompanies overflow, underflow, integer overflow
// - Quad-to-long overflow sets inexact, never traps it
// - Integer overflow keeps low bits, trap if enabled
// - Float-to-quad outside signed 64-bit range overflows
// - Quad-to-long outside signed 32-bit range overflows
// - Software completion always sent, never recorded
// - Input exceptions suppress concurrent output exceptions
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module fp_exception_detect (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Completing operation from the datapath
  input  wire fpx_pkg::fp_op_t            op_in,
  // Report to the instruction issue unit
  output fpx_pkg::issue_rpt_t             issue_rpt,
  // Register port
  input  wire logic [3:0]                 reg_addr,
  input  wire logic [fpx_pkg::EXC_W-1:0]  reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [fpx_pkg::EXC_W-1:0]  reg_rdata,
  // Interrupt
  output logic                            irq
);

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------

  logic [fpx_pkg::EXC_W-1:0] input_exc;
  logic [fpx_pkg::EXC_W-1:0] output_exc;
  logic [fpx_pkg::EXC_W-1:0] recorded;
  logic [fpx_pkg::EXC_W-1:0] next_trap;
  logic [63:0]               next_result;
  logic                      next_unpred;

  fpx_classify u_classify (
    .op         (op_in),
    .input_exc  (input_exc),
    .output_exc (output_exc)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  logic [fpx_pkg::EXC_W-1:0] fp_control_reg;
  logic [fpx_pkg::EXC_W-1:0] trap_enable;
  logic [fpx_pkg::EXC_W-1:0] irq_status;
  logic [fpx_pkg::EXC_W-1:0] irq_mask;

  // Input exceptions win over output exceptions
  always_comb begin
    if (input_exc != '0)
      recorded = input_exc;
    else
      recorded = output_exc;
  end

  // Trap selection: always-on and enabled traps
  always_comb begin
    next_trap = '0;
    next_trap[fpx_pkg::BIT_BAD] = recorded[fpx_pkg::BIT_BAD];
    next_trap[fpx_pkg::BIT_DZ]  = recorded[fpx_pkg::BIT_DZ];
    next_trap[fpx_pkg::BIT_OVF] = recorded[fpx_pkg::BIT_OVF];
    next_trap[fpx_pkg::BIT_UNF] = recorded[fpx_pkg::BIT_UNF]
                                 && trap_enable[fpx_pkg::BIT_UNF];
    next_trap[fpx_pkg::BIT_IOV] = recorded[fpx_pkg::BIT_IOV]
                                 && trap_enable[fpx_pkg::BIT_IOV];
    // Inexact trap needs both the register enable and an opcode that allows it
    next_trap[fpx_pkg::BIT_INEXACT] = recorded[fpx_pkg::BIT_INEXACT]
        && trap_enable[fpx_pkg::BIT_INEXACT] && op_in.inexact_trap_en
        && (op_in.kind != fpx_pkg::OP_Q_TO_LONG);
    if (next_trap[fpx_pkg::BIT_INEXACT] == 1'b0 && trap_enable[fpx_pkg::BIT_INEXACT]
        && op_in.inexact_trap_en && op_in.kind != fpx_pkg::OP_Q_TO_LONG
        && (next_trap[fpx_pkg::BIT_OVF] || next_trap[fpx_pkg::BIT_UNF]
            || next_trap[fpx_pkg::BIT_IOV]))
      next_trap[fpx_pkg::BIT_INEXACT] = 1'b1;
  end

  // Destination forcing
  always_comb begin
    next_result = op_in.result;
    next_unpred = recorded[fpx_pkg::BIT_BAD] || recorded[fpx_pkg::BIT_DZ]
               || recorded[fpx_pkg::BIT_OVF];
    if (recorded[fpx_pkg::BIT_UNF])
      next_result = fpx_pkg::TRUE_ZERO;
  end

  // ----------------------------------------------------------------
  // Issue report
  // ----------------------------------------------------------------

  // Trap, completion and result leave together in one registered cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      issue_rpt <= '0;
    end else begin
      issue_rpt.valid                <= op_in.valid;
      issue_rpt.trap                 <= op_in.valid ? next_trap : '0;
      issue_rpt.sw_completion        <= op_in.valid && op_in.sw_completion;
      issue_rpt.result               <= next_result;
      issue_rpt.result_unpredictable <= op_in.valid && next_unpred;
    end
  end

  // ----------------------------------------------------------------
  // Control register and trap enables
  // ----------------------------------------------------------------

  logic wr_ctrl;
  logic wr_enable;
  logic wr_status;
  logic wr_mask;

  assign wr_ctrl   = reg_wr && (reg_addr == fpx_pkg::REG_CTRL);
  assign wr_enable = reg_wr && (reg_addr == fpx_pkg::REG_ENABLE);
  assign wr_status = reg_wr && (reg_addr == fpx_pkg::REG_IRQ_ST);
  assign wr_mask   = reg_wr && (reg_addr == fpx_pkg::REG_IRQ_MSK);

  // Sticky exception bits; software writes ones to clear, hardware set wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fp_control_reg <= fpx_pkg::CTRL_RST;
    end else begin
      fp_control_reg <= ((wr_ctrl ? (fp_control_reg & ~reg_wdata) : fp_control_reg)
                        | (op_in.valid ? recorded : '0));
    end
  end

  // Trap enable bits (only underflow, inexact, integer overflow take effect)
  always_ff @(posedge clk) begin
    if (!resetn)
      trap_enable <= fpx_pkg::ENABLE_RST;
    else if (wr_enable)
      trap_enable <= reg_wdata;
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------

  // Each recorded exception sets a sticky status bit; write one to clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= ((wr_status ? (irq_status & ~reg_wdata) : irq_status)
                    | (op_in.valid ? recorded : '0));
    end
  end

  // Interrupt mask
  always_ff @(posedge clk) begin
    if (!resetn)
      irq_mask <= fpx_pkg::MASK_RST;
    else if (wr_mask)
      irq_mask <= reg_wdata;
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------

  // Read data valid the cycle after the read strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        fpx_pkg::REG_CTRL:    reg_rdata <= fp_control_reg;
        fpx_pkg::REG_ENABLE:  reg_rdata <= trap_enable;
        fpx_pkg::REG_IRQ_ST:  reg_rdata <= irq_status;
        fpx_pkg::REG_IRQ_MSK: reg_rdata <= irq_mask;
        default:              reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // fp_exception_detect

// ---- fpx_pkg.sv ----
// Package: shared types and constants for the floating-point exception detector
package fpx_pkg;

  // Operand classes supplied by the datapath
  typedef enum logic [2:0] {
    CLS_ZERO     = 3'b000,
    CLS_FINITE   = 3'b001,
    CLS_INF      = 3'b010,
    CLS_NAN      = 3'b011,
    CLS_DENORM   = 3'b100,
    CLS_RESERVED = 3'b101,
    CLS_DIRTY0   = 3'b110
  } operand_class_t;

  // Operation kinds that matter for exception rules
  typedef enum logic [2:0] {
    OP_NOEXC     = 3'b000,
    OP_ARITH     = 3'b001,
    OP_DIVIDE    = 3'b010,
    OP_F_TO_QUAD = 3'b011,
    OP_Q_TO_LONG = 3'b100,
    OP_COMPARE   = 3'b101
  } op_kind_t;

  // Exception bit positions in status, mask and trap vectors
  localparam int EXC_W       = 6;
  localparam int BIT_BAD     = 0;
  localparam int BIT_DZ      = 1;
  localparam int BIT_OVF     = 2;
  localparam int BIT_UNF     = 3;
  localparam int BIT_INEXACT = 4;
  localparam int BIT_IOV     = 5;

  // Register indices on the plain register port
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_ENABLE  = 4'h1;
  localparam logic [3:0] REG_IRQ_ST  = 4'h2;
  localparam logic [3:0] REG_IRQ_MSK = 4'h3;

  // Reset values
  localparam logic [EXC_W-1:0] CTRL_RST   = 6'h00;
  localparam logic [EXC_W-1:0] ENABLE_RST = 6'h00;
  localparam logic [EXC_W-1:0] MASK_RST   = 6'h00;

  // Result forcing
  localparam logic [63:0] TRUE_ZERO = 64'h0000000000000000;

  // One completing instruction as seen by the detector
  typedef struct packed {
    logic           valid;
    op_kind_t       kind;
    logic           ieee;
    logic           fp_dest;
    operand_class_t class_a;
    operand_class_t class_b;
    logic           use_b;
    logic           round_over;
    logic           round_under;
    logic           round_inexact;
    logic           int_range_bad;
    logic           sw_completion;
    logic           inexact_trap_en;
    logic [63:0]    result;
  } fp_op_t;

  // Report toward the instruction issue unit
  typedef struct packed {
    logic             valid;
    logic [EXC_W-1:0] trap;
    logic             sw_completion;
    logic [63:0]      result;
    logic             result_unpredictable;
  } issue_rpt_t;

endpackage

// ---- fpx_classify.sv ----
// Combinational classifier: input and output exceptions for one operation
`timescale 1ns/10ps
module fpx_classify (
  // Operation in
  input  wire fpx_pkg::fp_op_t      op,
  // Raw exception vectors out
  output logic [fpx_pkg::EXC_W-1:0] input_exc,
  output logic [fpx_pkg::EXC_W-1:0] output_exc
);

  logic can_except;
  logic bad_a;
  logic bad_b;
  logic num_valid;

  // Operand validity for each format
  always_comb begin
    can_except = op.valid && (op.kind != fpx_pkg::OP_NOEXC);
    if (op.ieee) begin
      bad_a = (op.class_a == fpx_pkg::CLS_NAN) || (op.class_a == fpx_pkg::CLS_INF)
           || (op.class_a == fpx_pkg::CLS_DENORM);
      bad_b = op.use_b && ((op.class_b == fpx_pkg::CLS_NAN)
           || (op.class_b == fpx_pkg::CLS_INF) || (op.class_b == fpx_pkg::CLS_DENORM));
    end else begin
      bad_a = (op.class_a == fpx_pkg::CLS_RESERVED)
           || (op.class_a == fpx_pkg::CLS_DIRTY0);
      bad_b = op.use_b && ((op.class_b == fpx_pkg::CLS_RESERVED)
           || (op.class_b == fpx_pkg::CLS_DIRTY0));
    end
    num_valid = !bad_a;
  end

  // Input exceptions: bad operand and divide by zero
  always_comb begin
    input_exc = '0;
    if (can_except) begin
      input_exc[fpx_pkg::BIT_BAD] = bad_a || bad_b;
      if (op.kind == fpx_pkg::OP_DIVIDE && !(bad_a || bad_b)
          && op.class_b == fpx_pkg::CLS_ZERO) begin
        if (op.ieee) begin
          if (op.class_a == fpx_pkg::CLS_ZERO)
            input_exc[fpx_pkg::BIT_BAD] = 1'b1;
          else
            input_exc[fpx_pkg::BIT_DZ] = num_valid;
        end else begin
          input_exc[fpx_pkg::BIT_DZ] = num_valid;
        end
      end
    end
  end

  // Output exceptions from rounding and conversion results
  always_comb begin
    output_exc = '0;
    if (can_except) begin
      output_exc[fpx_pkg::BIT_OVF] = op.fp_dest && op.round_over;
      output_exc[fpx_pkg::BIT_UNF] = op.fp_dest && op.round_under;
      output_exc[fpx_pkg::BIT_INEXACT] = op.round_inexact;
      if (op.kind == fpx_pkg::OP_F_TO_QUAD || op.kind == fpx_pkg::OP_Q_TO_LONG)
        output_exc[fpx_pkg::BIT_IOV] = op.int_range_bad;
      if (output_exc[fpx_pkg::BIT_IOV])
        output_exc[fpx_pkg::BIT_INEXACT] = 1'b1;
    end
  end

endmodule // fpx_classify

// ---- fpx_checker.sv ----
// Checker: port-level properties of the exception detector
`timescale 1ns/10ps
module fpx_checker (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      resetn,
  // Datapath and report
  input wire fpx_pkg::fp_op_t           op_in,
  input wire fpx_pkg::issue_rpt_t       issue_rpt,
  // Register port and interrupt
  input wire logic [3:0]                reg_addr,
  input wire logic [fpx_pkg::EXC_W-1:0] reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [fpx_pkg::EXC_W-1:0] reg_rdata,
  input wire logic                      irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Arithmetic op with two clean operands
  sequence s_clean;
    op_in.valid && op_in.kind == fpx_pkg::OP_ARITH && op_in.use_b
      && op_in.class_a == fpx_pkg::CLS_FINITE && op_in.class_b == fpx_pkg::CLS_FINITE;
  endsequence
  // Report timing and completion pairing
  AST_RPT_NEXT: assert property (op_in.valid |=> issue_rpt.valid)
    else $error("report missing one cycle after op");
  AST_RPT_IDLE: assert property (!op_in.valid |=> !issue_rpt.valid)
    else $error("report without op");
  AST_SWC_PASS: assert property (op_in.valid |=> issue_rpt.sw_completion == $past(op_in.sw_completion))
    else $error("completion not passed");
  // Input exceptions
  AST_NAN_BAD: assert property (op_in.valid && op_in.ieee && op_in.kind == fpx_pkg::OP_ARITH
    && op_in.class_a == fpx_pkg::CLS_NAN |=> issue_rpt.trap[fpx_pkg::BIT_BAD]
    && !issue_rpt.trap[fpx_pkg::BIT_OVF] && issue_rpt.result_unpredictable)
    else $error("nan operand not flagged");
  AST_ZERO_ZERO: assert property (op_in.valid && op_in.ieee && op_in.kind == fpx_pkg::OP_DIVIDE
    && op_in.class_a == fpx_pkg::CLS_ZERO && op_in.class_b == fpx_pkg::CLS_ZERO
    |=> issue_rpt.trap[fpx_pkg::BIT_BAD] && !issue_rpt.trap[fpx_pkg::BIT_DZ])
    else $error("zero over zero wrong");
  AST_NOEXC: assert property (op_in.valid && op_in.kind == fpx_pkg::OP_NOEXC
    |=> issue_rpt.trap == '0)
    else $error("exception-free op trapped");
  // Output exceptions
  AST_UNF_ZERO: assert property ((s_clean ##0 op_in.round_under && !op_in.round_over
    && op_in.fp_dest)
    |=> issue_rpt.result == fpx_pkg::TRUE_ZERO)
    else $error("underflow result not zero");
  AST_OVF: assert property ((s_clean ##0 op_in.fp_dest && op_in.round_over)
    |=> issue_rpt.trap[fpx_pkg::BIT_OVF] && issue_rpt.result_unpredictable)
    else $error("overflow not trapped");
  AST_Q2L_NO_INEXACT: assert property (op_in.valid && op_in.kind == fpx_pkg::OP_Q_TO_LONG
    |=> !issue_rpt.trap[fpx_pkg::BIT_INEXACT])
    else $error("quad to long inexact trap");
  // Read data only after a read
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data without read");
endmodule // fpx_checker
bind fp_exception_detect fpx_checker u_chk (.clk(clk), .resetn(resetn), .op_in(op_in),
  .issue_rpt(issue_rpt), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// ---- issue_unit_model.sv ----
// Partner: issue unit keeping the completion summary
`timescale 1ns/10ps
module issue_unit_model (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // Report from the detector
  input  wire fpx_pkg::issue_rpt_t  issue_rpt,
  // Summary state
  output logic                      swc_summary
);
  // Summary bit set when completion meets a trap of the same op
  always_ff @(posedge clk) begin
    if (!resetn) begin
      swc_summary <= 1'b0;
    end else if (issue_rpt.valid && issue_rpt.sw_completion && (|issue_rpt.trap)) begin
      swc_summary <= 1'b1;
    end
  end
endmodule // issue_unit_model

// ---- fp_exception_detect_test.sv ----
// Testbench: table-driven and directed checks of the exception detector
`timescale 1ns/10ps
module fp_exception_detect_test;
  // ----------------
  // Signals
  // ----------------
  typedef struct packed {
    fpx_pkg::fp_op_t op;
    logic [5:0]      trap;
    logic [5:0]      rec;
  } row_t;
  localparam logic [63:0] RES = 64'h0123456789ABCDEF;
  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  fpx_pkg::fp_op_t     op_in = '0;
  fpx_pkg::fp_op_t     no_inexact;
  fpx_pkg::issue_rpt_t issue_rpt;
  logic [3:0]          reg_addr = 4'h0;
  logic [5:0]          reg_wdata = 6'h00;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [5:0]          reg_rdata;
  logic                irq;
  logic                swc_summary;
  logic [5:0]          rv;
  logic [1:0]          iq;
  int                  n_mismatch = 0;
  int                  num_checks = 0;
  row_t                rows [12];
  fp_exception_detect u_dut (.clk(clk), .resetn(resetn), .op_in(op_in), .issue_rpt(issue_rpt),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  issue_unit_model u_iu (.clk(clk), .resetn(resetn), .issue_rpt(issue_rpt),
    .swc_summary(swc_summary));
  // Clock
  always #2.5 clk = ~clk;
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [5:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic send(input fpx_pkg::fp_op_t o);
    @(posedge clk);
    op_in <= o;
    @(posedge clk);
    op_in <= '0;
    #1;
  endtask
  // Flags are {over, under, inexact, range, completion}
  function automatic fpx_pkg::fp_op_t mk(input fpx_pkg::op_kind_t k, input logic ie,
      input fpx_pkg::operand_class_t a, input fpx_pkg::operand_class_t b, input logic [4:0] f);
    return '{1'b1, k, ie, k < fpx_pkg::OP_F_TO_QUAD, a, b, 1'b1, f[4], f[3], f[2], f[1], f[0],
      1'b1, RES};
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    rows[0] = '{mk(fpx_pkg::OP_ARITH, 1, fpx_pkg::CLS_NAN, fpx_pkg::CLS_FINITE, 5'h00), 6'h01, 6'h01};
    rows[1] = '{mk(fpx_pkg::OP_ARITH, 1, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_DENORM, 5'h10), 6'h01, 6'h01};
    rows[2] = '{mk(fpx_pkg::OP_ARITH, 0, fpx_pkg::CLS_RESERVED, fpx_pkg::CLS_FINITE, 5'h00), 6'h01, 6'h01};
    rows[3] = '{mk(fpx_pkg::OP_NOEXC, 0, fpx_pkg::CLS_DIRTY0, fpx_pkg::CLS_FINITE, 5'h01), 6'h00, 6'h00};
    rows[4] = '{mk(fpx_pkg::OP_DIVIDE, 1, fpx_pkg::CLS_ZERO, fpx_pkg::CLS_ZERO, 5'h00), 6'h01, 6'h01};
    rows[5] = '{mk(fpx_pkg::OP_DIVIDE, 1, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_ZERO, 5'h00), 6'h02, 6'h02};
    rows[6] = '{mk(fpx_pkg::OP_DIVIDE, 0, fpx_pkg::CLS_ZERO, fpx_pkg::CLS_ZERO, 5'h00), 6'h02, 6'h02};
    rows[7] = '{mk(fpx_pkg::OP_ARITH, 1, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_FINITE, 5'h14), 6'h14, 6'h14};
    rows[8] = '{mk(fpx_pkg::OP_ARITH, 1, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_FINITE, 5'h0C), 6'h18, 6'h18};
    rows[9] = '{mk(fpx_pkg::OP_ARITH, 1, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_FINITE, 5'h04), 6'h10, 6'h10};
    rows[10] = '{mk(fpx_pkg::OP_F_TO_QUAD, 1, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_FINITE, 5'h02), 6'h30, 6'h30};
    rows[11] = '{mk(fpx_pkg::OP_Q_TO_LONG, 0, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_FINITE, 5'h02), 6'h20, 6'h30};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    // Reset values, unmapped place ignored
    wr(4'h9, 6'h3F);
    repeat (2) begin
      rd(4'h9);
      chk(rv, 6'h00);
    end
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0]);
      chk(rv, 6'h00);
    end
    chk(rv | irq, 6'h00);
    wr(fpx_pkg::REG_ENABLE, 6'h38);
    foreach (rows[i]) begin
      wr(fpx_pkg::REG_CTRL, 6'h3F);
      send(rows[i].op);
      chk(issue_rpt.valid, 1'b1);
      chk(issue_rpt.trap, rows[i].trap);
      chk(issue_rpt.sw_completion, rows[i].op.sw_completion);
      chk(issue_rpt.result_unpredictable, |rows[i].rec[2:0]);
      if (rows[i].rec[2:0] == 3'h0) chk(issue_rpt.result, rows[i].rec[3] ? 64'h0 : RES);
      rd(fpx_pkg::REG_CTRL);
      chk(rv, rows[i].rec);
    end
    chk(swc_summary, 1'b0);
    // Opcode without inexact permission never traps inexact
    no_inexact = mk(fpx_pkg::OP_ARITH, 1, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_FINITE, 5'h04);
    no_inexact.inexact_trap_en = 1'b0;
    send(no_inexact);
    chk(issue_rpt.trap, 6'h00);
    // Disabled traps still record, sticky bits stay
    wr(fpx_pkg::REG_ENABLE, 6'h00);
    send(mk(fpx_pkg::OP_ARITH, 1, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_FINITE, 5'h0C));
    chk(issue_rpt.trap, 6'h00);
    chk(issue_rpt.result, 64'h0);
    rd(fpx_pkg::REG_CTRL);
    chk(rv, 6'h38);
    // Back-to-back ops with completion
    @(posedge clk);
    op_in <= mk(fpx_pkg::OP_ARITH, 1, fpx_pkg::CLS_NAN, fpx_pkg::CLS_FINITE, 5'h01);
    @(posedge clk);
    op_in <= mk(fpx_pkg::OP_DIVIDE, 1, fpx_pkg::CLS_FINITE, fpx_pkg::CLS_ZERO, 5'h00);
    #1 chk(issue_rpt.trap, 6'h01);
    @(posedge clk);
    op_in <= '0;
    #1 chk(issue_rpt.trap, 6'h02);
    chk(swc_summary, 1'b1);
    // Interrupt status, mask and clear
    rd(fpx_pkg::REG_IRQ_ST);
    chk(rv, 6'h3F);
    wr(fpx_pkg::REG_IRQ_MSK, 6'h00);
    iq[0] = irq;
    wr(fpx_pkg::REG_IRQ_MSK, 6'h3F);
    iq[1] = irq;
    chk(iq, 2'b10);
    wr(fpx_pkg::REG_IRQ_ST, 6'h3F);
    chk(irq, 1'b0);
    wr(fpx_pkg::REG_IRQ_MSK, 6'h00);
    chk(irq, 1'b0);
    // Hardware set beats a same-cycle write-one clear
    @(posedge clk);
    reg_addr <= fpx_pkg::REG_CTRL;
    reg_wdata <= 6'h3F;
    reg_wr <= 1'b1;
    op_in <= mk(fpx_pkg::OP_ARITH, 1, fpx_pkg::CLS_NAN, fpx_pkg::CLS_FINITE, 5'h00);
    @(posedge clk);
    reg_wr <= 1'b0;
    op_in <= '0;
    rd(fpx_pkg::REG_CTRL);
    chk(rv, 6'h01);
    // Mid-run reset clears sticky state and the interrupt
    wr(fpx_pkg::REG_IRQ_MSK, 6'h3F);
    chk(irq, 1'b1);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 chk(irq, 1'b0);
    chk(issue_rpt.valid, 1'b0);
    rd(fpx_pkg::REG_CTRL);
    chk(rv, 6'h00);
    rd(fpx_pkg::REG_IRQ_MSK);
    chk(rv, 6'h00);
    complete_run;
  end
endmodule // fp_exception_detect_test
